// >>> design/cspr_regs.sv
`timescale 1ns/100ps
module cspr_regs
	import cspr_pkg::*;
(
	input  wire logic           mclk,
	input  wire logic           rst,
	input  wire cspr_access_t   acc_in,
	input  wire cspr_flag_req_t flag_req,
	input  wire logic           acc_load,
	input  wire logic [7:0]     acc_value,
	input  wire logic           push_req,
	input  wire logic           pop_req,
	output logic [7:0]          rdata,
	output logic                rbit,
	output logic                unmapped,
	output logic [7:0]          status_word,
	output logic [7:0]          main_operand,
	output logic [7:0]          stack_top,
	output logic [15:0]         data_pointer,
	output logic [7:0]          bank_base,
	output logic                push_we,
	output logic [7:0]          push_addr
);
	logic [7:0] status_ff;
	logic [7:0] main_ff;
	logic [7:0] aux_ff;
	logic [7:0] sp_ff;
	logic [7:0] dpl_ff;
	logic [7:0] dph_ff;
	logic [7:0] rdata_ff;
	logic       rbit_ff;
	logic       unmapped_ff;
	logic [7:0] base_ff;
	logic       push_we_ff;
	logic [7:0] push_addr_ff;
	logic [7:0] nxt_main;
	logic [7:0] nxt_status;
	logic [7:0] rd_mux;
	logic       parity_now;
	logic [7:0] base_now;
	logic       hit_any;

	function automatic logic bit_capable(input logic [7:0] a);
		return a[2:0] == BIT_SPACE_LOW;
	endfunction : bit_capable

	function automatic logic [7:0] merge(input logic [7:0] old, input cspr_access_t a);
		logic [7:0] r;
		r = old;
		if (a.bit_mode)
			r[a.bit_pos] = a.wdata[0];
		else
			r = a.wdata;
		return r;
	endfunction : merge

	// bit access is honoured only at bit-capable addresses
	function automatic logic wr_hit(input cspr_access_t a, input logic [7:0] reg_addr);
		return a.wr && a.addr == reg_addr && (!a.bit_mode || bit_capable(reg_addr));
	endfunction : wr_hit

	cspr_parity #(.WIDTH(8)) u_parity (
		.value (nxt_main),
		.odd   (parity_now)
	);

	cspr_bank_sel u_bank (
		.bank ({status_ff[POS_BANK_HIGH], status_ff[POS_BANK_LOW]}),
		.base (base_now)
	);

	// a software write wins over an execution-logic load in the same cycle
	always_comb
	begin
		nxt_main = main_ff;
		if (acc_load)
			nxt_main = acc_value;
		if (wr_hit(acc_in, ADDR_MAIN_OPND))
			nxt_main = merge(main_ff, acc_in);
	end

	always_comb
	begin
		nxt_status = status_ff;
		unique case (flag_req.op)
			CSPR_OP_ADD:
			begin
				nxt_status[POS_CARRY]      = flag_req.carry;
				nxt_status[POS_HALF_CARRY] = flag_req.half_carry;
				nxt_status[POS_OVERFLOW]   = flag_req.signed_ovf;
			end
			CSPR_OP_MUL:
			begin
				nxt_status[POS_CARRY]    = 1'b0;
				nxt_status[POS_OVERFLOW] = flag_req.mul_high != 8'h00;
			end
			CSPR_OP_DIV:
			begin
				nxt_status[POS_CARRY]    = 1'b0;
				nxt_status[POS_OVERFLOW] = flag_req.div_zero;
			end
			CSPR_OP_NONE:
			begin
				nxt_status = status_ff;
			end
			default:
			begin
				nxt_status = status_ff;
			end
		endcase
		if (wr_hit(acc_in, ADDR_STATUS))
			nxt_status = merge(nxt_status, acc_in);
		// parity is never taken from a write; it tracks the operand
		nxt_status[POS_PARITY] = parity_now;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			main_ff <= RST_MAIN_OPND;
		else
			main_ff <= nxt_main;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			status_ff <= RST_STATUS;
		else
			status_ff <= nxt_status;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			aux_ff <= RST_AUX_OPND;
		else if (wr_hit(acc_in, ADDR_AUX_OPND))
			aux_ff <= merge(aux_ff, acc_in);
	end

	// stack: push bumps the pointer and flags a store at old pointer+1 at the same edge; pop only drops it
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sp_ff <= RST_STACK_TOP;
		else if (wr_hit(acc_in, ADDR_STACK_TOP))
			sp_ff <= acc_in.wdata;
		else if (push_req)
			sp_ff <= sp_ff + 8'h01;
		else if (pop_req)
			sp_ff <= sp_ff - 8'h01;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			push_we_ff   <= 1'b0;
			push_addr_ff <= 8'h00;
		end
		else
		begin
			push_we_ff   <= push_req;
			push_addr_ff <= sp_ff + 8'h01;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			dpl_ff <= RST_DPTR;
			dph_ff <= RST_DPTR;
		end
		else
		begin
			if (wr_hit(acc_in, ADDR_DPTR_LOW))
				dpl_ff <= acc_in.wdata;
			if (wr_hit(acc_in, ADDR_DPTR_HIGH))
				dph_ff <= acc_in.wdata;
		end
	end

	always_comb
	begin
		hit_any = 1'b1;
		unique case (acc_in.addr)
			ADDR_STACK_TOP: rd_mux = sp_ff;
			ADDR_DPTR_LOW:  rd_mux = dpl_ff;
			ADDR_DPTR_HIGH: rd_mux = dph_ff;
			ADDR_STATUS:    rd_mux = status_ff;
			ADDR_MAIN_OPND: rd_mux = main_ff;
			ADDR_AUX_OPND:  rd_mux = aux_ff;
			default:
			begin
				// reserved space reads zero rather than undefined data
				rd_mux  = 8'h00;
				hit_any = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rdata_ff    <= 8'h00;
			rbit_ff     <= 1'b0;
			unmapped_ff <= 1'b0;
		end
		else
		begin
			rdata_ff    <= rd_mux;
			rbit_ff     <= bit_capable(acc_in.addr) ? rd_mux[acc_in.bit_pos] : 1'b0;
			unmapped_ff <= !hit_any || (acc_in.bit_mode && !bit_capable(acc_in.addr));
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			base_ff <= 8'h00;
		else
			base_ff <= base_now;
	end

	assign rdata        = rdata_ff;
	assign rbit         = rbit_ff;
	assign unmapped     = unmapped_ff;
	assign status_word  = status_ff;
	assign main_operand = main_ff;
	assign stack_top    = sp_ff;
	assign data_pointer = {dph_ff, dpl_ff};
	assign bank_base    = base_ff;
	assign push_we      = push_we_ff;
	assign push_addr    = push_addr_ff;

	a_parity_track: assert property (@(posedge mclk) disable iff (rst)
		status_ff[POS_PARITY] == ^main_ff)
		else $error("parity flag differs from operand parity");

	a_stack_reset: assert property (@(posedge mclk) $fell(rst) |-> sp_ff == 8'h07)
		else $error("stack pointer not 07 after reset");

	sequence s_push;
		push_req && !acc_in.wr;
	endsequence

	a_push_order: assert property (@(posedge mclk) disable iff (rst)
		s_push |=> push_we && push_addr == $past(sp_ff) + 8'h01 && sp_ff == push_addr)
		else $error("push address or pointer step wrong");

	a_mul_ovf: assert property (@(posedge mclk) disable iff (rst)
		flag_req.op == CSPR_OP_MUL && !acc_in.wr
		|=> status_ff[POS_OVERFLOW] == ($past(flag_req.mul_high) != 8'h00))
		else $error("multiply overflow flag wrong");

	a_div_ovf: assert property (@(posedge mclk) disable iff (rst)
		flag_req.op == CSPR_OP_DIV && !acc_in.wr
		|=> status_ff[POS_OVERFLOW] == $past(flag_req.div_zero))
		else $error("divide overflow flag wrong");

	a_bank_base: assert property (@(posedge mclk) disable iff (rst)
		##1 bank_base == {3'h0, $past(status_ff[4:3]), 3'h0})
		else $error("bank base mismatch");

	a_byte_only: assert property (@(posedge mclk) disable iff (rst)
		acc_in.wr && acc_in.bit_mode && acc_in.addr == ADDR_STACK_TOP && !push_req && !pop_req
		|=> $stable(sp_ff))
		else $error("bit write reached byte-only register");

	a_status_read: assert property (@(posedge mclk) disable iff (rst)
		!acc_in.wr && acc_in.addr == ADDR_STATUS |=> rdata == $past(status_ff))
		else $error("status read wrong");

	a_main_write: assert property (@(posedge mclk) disable iff (rst)
		acc_in.wr && !acc_in.bit_mode && acc_in.addr == ADDR_MAIN_OPND
		|=> main_ff == $past(acc_in.wdata))
		else $error("operand write lost");

endmodule : cspr_regs

// >>> common/cspr_pkg.sv
package cspr_pkg;

	// special-function addresses
	localparam logic [7:0] ADDR_STACK_TOP  = 8'h81;
	localparam logic [7:0] ADDR_DPTR_LOW   = 8'h82;
	localparam logic [7:0] ADDR_DPTR_HIGH  = 8'h83;
	localparam logic [7:0] ADDR_STATUS     = 8'hD0;
	localparam logic [7:0] ADDR_MAIN_OPND  = 8'hE0;
	localparam logic [7:0] ADDR_AUX_OPND   = 8'hF0;

	// status word field positions
	localparam int unsigned POS_CARRY      = 7;
	localparam int unsigned POS_HALF_CARRY = 6;
	localparam int unsigned POS_USER_ZERO  = 5;
	localparam int unsigned POS_BANK_HIGH  = 4;
	localparam int unsigned POS_BANK_LOW   = 3;
	localparam int unsigned POS_OVERFLOW   = 2;
	localparam int unsigned POS_USER_ONE   = 1;
	localparam int unsigned POS_PARITY     = 0;

	// reset values
	localparam logic [7:0] RST_STATUS      = 8'h00;
	localparam logic [7:0] RST_MAIN_OPND   = 8'h00;
	localparam logic [7:0] RST_AUX_OPND    = 8'h00;
	localparam logic [7:0] RST_STACK_TOP   = 8'h07;
	localparam logic [7:0] RST_DPTR        = 8'h00;

	// low three bits of a bit-addressable address
	localparam logic [2:0] BIT_SPACE_LOW   = 3'h0;
	localparam logic [7:0] MUL_LIMIT       = 8'hFF;

	// flag update request from the execution logic
	typedef enum logic [3:0] {
		CSPR_OP_NONE = 4'h1,
		CSPR_OP_ADD  = 4'h2,
		CSPR_OP_MUL  = 4'h4,
		CSPR_OP_DIV  = 4'h8
	} cspr_op_t;

	typedef struct packed {
		cspr_op_t   op;
		logic       carry;
		logic       half_carry;
		logic       signed_ovf;
		logic [7:0] mul_high;
		logic       div_zero;
	} cspr_flag_req_t;

	// register-port access
	typedef struct packed {
		logic       wr;
		logic       bit_mode;
		logic [7:0] addr;
		logic [2:0] bit_pos;
		logic [7:0] wdata;
	} cspr_access_t;

endpackage : cspr_pkg

// >>> design/cspr_parity.sv
`timescale 1ns/100ps
module cspr_parity
	import cspr_pkg::*;
#(
	parameter int unsigned WIDTH = 8
)(
	input  wire logic [WIDTH-1:0] value,
	output logic                  odd
);
	if (WIDTH < 1) begin : g_chk
		$error("cspr_parity: width must be at least 1");
	end

	// odd count of ones reads one
	assign odd = ^value;

endmodule : cspr_parity

// >>> design/cspr_bank_sel.sv
`timescale 1ns/100ps
module cspr_bank_sel
	import cspr_pkg::*;
(
	input  wire logic [1:0] bank,
	output logic [7:0]      base
);
	// one bank active at a time: base is bank times eight
	assign base = {3'h0, bank, 3'h0};

endmodule : cspr_bank_sel

// >>> tb/cspr_exec_model.sv
`timescale 1ns/100ps
module cspr_exec_model
	import cspr_pkg::*;
(
	input  wire logic   mclk,
	output cspr_flag_req_t flag_req,
	output logic        acc_load,
	output logic [7:0]  acc_value,
	output logic        push_req,
	output logic        pop_req
);
	initial
	begin
		flag_req  = {CSPR_OP_NONE, 12'h000};
		acc_load  = 1'b0;
		acc_value = 8'h00;
		push_req  = 1'b0;
		pop_req   = 1'b0;
	end
	task flag(input cspr_op_t op, input logic c, input logic h, input logic f);
		@(posedge mclk) flag_req <= {op, c, h, f, 7'h00, f, f};
		@(posedge mclk) flag_req <= {CSPR_OP_NONE, 12'h000};
	endtask : flag
	task load(input logic [7:0] v);
		@(posedge mclk)
		begin
			acc_load  <= 1'b1;
			acc_value <= v;
		end
		@(posedge mclk) acc_load <= 1'b0;
	endtask : load
	task push(input logic up);
		@(posedge mclk) {push_req, pop_req} <= {up, !up};
		@(posedge mclk) {push_req, pop_req} <= 2'b00;
	endtask : push
endmodule : cspr_exec_model

// >>> tb/cspr_regs_bench.sv
`timescale 1ns/100ps
module cspr_regs_bench;
	import cspr_pkg::*;
	logic           mclk = 1'b0;
	logic           rst  = 1'b1;
	cspr_access_t   acc_in = '0;
	cspr_flag_req_t flag_req;
	logic           acc_load, push_req, pop_req, rbit, unmapped, push_we;
	logic [7:0]     acc_value, rdata, status_word, main_operand, stack_top, bank_base, push_addr;
	logic [15:0]    data_pointer;
	logic [7:0]     m [0:255];
	logic [7:0]     adr [0:5] = '{ADDR_STACK_TOP, ADDR_DPTR_LOW, ADDR_DPTR_HIGH,
		ADDR_STATUS, ADDR_MAIN_OPND, ADDR_AUX_OPND};
	cspr_op_t       ops [0:5] = '{CSPR_OP_ADD, CSPR_OP_ADD, CSPR_OP_MUL, CSPR_OP_MUL,
		CSPR_OP_DIV, CSPR_OP_DIV};
	int             err_count = 0;
	int             check_count = 0;
	int             i;
	logic [7:0]     r;
	always #50 mclk = ~mclk;
	cspr_regs cspr_regs_i (.mclk(mclk), .rst(rst), .acc_in(acc_in), .flag_req(flag_req),
		.acc_load(acc_load), .acc_value(acc_value), .push_req(push_req), .pop_req(pop_req),
		.rdata(rdata), .rbit(rbit), .unmapped(unmapped), .status_word(status_word),
		.main_operand(main_operand), .stack_top(stack_top), .data_pointer(data_pointer),
		.bank_base(bank_base), .push_we(push_we), .push_addr(push_addr));
	cspr_exec_model cspr_exec_model_i (.mclk(mclk), .flag_req(flag_req), .acc_load(acc_load),
		.acc_value(acc_value), .push_req(push_req), .pop_req(pop_req));
	function automatic logic mapped(input logic [7:0] a);
		return a inside {ADDR_STACK_TOP, ADDR_DPTR_LOW, ADDR_DPTR_HIGH, ADDR_STATUS,
			ADDR_MAIN_OPND, ADDR_AUX_OPND};
	endfunction : mapped
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		return (a == ADDR_STATUS) ? {m[a][7:1], ^m[ADDR_MAIN_OPND]} : m[a];
	endfunction : exp_rd
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// reads compared against the model
	task acc(input logic w, input logic b, input logic [7:0] a, input logic [2:0] p,
		input logic [7:0] d);
		logic ok;
		ok = mapped(a) && (!b || a[2:0] == BIT_SPACE_LOW);
		@(posedge mclk) acc_in <= {w, b, a, p, d};
		@(posedge mclk) acc_in <= '0;
		#1;
		if (w && ok && b)
			m[a][p] = d[0];
		else if (w && ok)
			m[a] = d;
		if (!w)
		begin
			chk(rdata, exp_rd(a));
			chk({7'h0, unmapped}, {7'h0, !ok});
			if (b)
				chk({7'h0, rbit}, {7'h0, ok} & (exp_rd(a) >> p));
		end
	endtask : acc
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial
	begin
		#500000;
		err_count++;
		end_of_test();
	end
	initial
	begin
		for (i = 0; i < 256; i++)
			m[i] = 8'h00;
		m[ADDR_STACK_TOP] = RST_STACK_TOP;
		r = $urandom(48);
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk(status_word, 8'h00);
		chk(main_operand, 8'h00);
		chk(stack_top, 8'h07);
		for (i = 0; i < 6; i++)
			acc(0, 0, adr[i], 0, 0);
		$display("reset test done");
		for (i = 0; i < 12; i++)
		begin
			acc(1, 0, adr[i % 6], 0, $urandom);
			acc(0, 0, adr[i % 6], 0, 0);
		end
		chk(data_pointer[15:8], m[ADDR_DPTR_HIGH]);
		chk(data_pointer[7:0], m[ADDR_DPTR_LOW]);
		$display("byte access test done");
		acc(1, 0, 8'h84, 0, 8'hA5);
		acc(0, 0, 8'h84, 0, 0);
		acc(1, 1, ADDR_STACK_TOP, 0, 8'h01);
		acc(0, 1, ADDR_STACK_TOP, 0, 0);
		acc(0, 0, ADDR_STACK_TOP, 0, 0);
		$display("reserved access test done");
		for (i = 0; i < 4; i++)
		begin
			acc(1, 1, ADDR_STATUS, POS_BANK_LOW, i % 2);
			acc(1, 1, ADDR_STATUS, POS_BANK_HIGH, i / 2);
			acc(0, 1, ADDR_STATUS, POS_BANK_HIGH, 0);
			chk(bank_base, {3'h0, m[ADDR_STATUS][4:3], 3'h0});
		end
		acc(1, 1, ADDR_MAIN_OPND, 2, 8'h01);
		acc(1, 1, ADDR_STATUS, POS_PARITY, {7'h0, ~^m[ADDR_MAIN_OPND]});
		acc(0, 1, ADDR_STATUS, POS_PARITY, 0);
		r = $urandom;
		cspr_exec_model_i.load(r);
		#1;
		m[ADDR_MAIN_OPND] = r;
		chk(main_operand, r);
		chk(status_word, exp_rd(ADDR_STATUS));
		$display("bit access test done");
		for (i = 0; i < 6; i++)
		begin
			r = $urandom;
			cspr_exec_model_i.flag(ops[i], r[0], r[1], ~i[0]);
			#1;
			m[ADDR_STATUS][7] = (ops[i] == CSPR_OP_ADD) & r[0];
			if (ops[i] == CSPR_OP_ADD)
				m[ADDR_STATUS][6] = r[1];
			m[ADDR_STATUS][2] = ~i[0];
			chk(status_word, exp_rd(ADDR_STATUS));
		end
		$display("flag test done");
		r = $urandom;
		acc(1, 0, ADDR_STACK_TOP, 0, r);
		cspr_exec_model_i.push(1'b1);
		#1;
		chk({7'h0, push_we}, 8'h01);
		chk(push_addr, r + 8'h01);
		chk(stack_top, r + 8'h01);
		cspr_exec_model_i.push(1'b0);
		#1;
		chk({7'h0, push_we}, 8'h00);
		chk(stack_top, r);
		$display("push test done");
		end_of_test();
	end
endmodule : cspr_regs_bench
